// >>> hw/sar_adc_params.svh
// constants for the serial readout sequencer of the sampling converter
// Functional notes
// (RQ1) output advances on each serial clock fall
// (RQ2) host samples on rising edge normally
// (RQ3) select falling starts conversion and transfer
// (RQ4) first 4.5 to 5 periods sample input
// (RQ5) after fifth fall drive one low null
// (RQ6) then sixteen result bits, top bit first
// (RQ7) after bottom bit, resend bottom-first order
// (RQ8) after top bit resent, float and ignore
// (RQ9) new conversion needs select high then low
// (RQ10) result coded as unsigned straight binary
// (RQ11) power down when done or select high
// (RQ12) select low after done: analog only down
// (RQ13) host may raise select to end early
// (RQ14) host runs fast clock, select high otherwise
// (RQ15) one bit decision per serial clock cycle
// (RQ16) select high floats output, sequencer to idle
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH

// result word
`define RESULT_WIDTH      16
`define RESULT_TOP_IDX    4'hF
`define RESULT_BOTTOM_IDX 4'h0
`define RESEND_FIRST_IDX  4'h1

// falls spent sampling, counted from zero; the fifth ends it
`define SAMPLE_LAST_FALL  3'h4

// clock rate and one bit decision time
`define MCLK_MHZ          40
`define BIT_DECISION_NS   167
// least time, rounded up to whole mclk cycles
`define BIT_DECISION_CYC  (((`BIT_DECISION_NS * `MCLK_MHZ) + 999) / 1000)
`define GAP_CNT_MAX       4'hF

`endif

// >>> hw/sar_adc_pkg.sv
// types shared by the serial readout sequencer
package sar_adc_pkg;

  // host-driven pins, both asynchronous to mclk
  typedef struct packed {
    logic cs_n;               // active-low select
    logic serial_shift_clock; // serial clock from the host
  } link_pins_t;

  // serial data pin as output plus enable
  typedef struct packed {
    logic dout;
    logic dout_oe;
  } serial_out_t;

  // sequencer states, gray along the transfer path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SAMPLE = 3'h1,
    ST_NULL   = 3'h3,
    ST_MSBF   = 3'h2,
    ST_LSBF   = 3'h6,
    ST_DONE   = 3'h4
  } seq_state_t;

endpackage

// >>> hw/sar_adc_serial_readout.sv
// conversion sequencer and three-wire serial result port
`timescale 1ns/1ps
`include "sar_adc_params.svh"

module sar_adc_serial_readout
  import sar_adc_pkg::*;
#(
  parameter int RESULT_W = `RESULT_WIDTH
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // host pins, asynchronous
  input  wire link_pins_t          pins,
  // code presented by the analog comparator path, mclk domain
  input  wire logic [RESULT_W-1:0] analog_code,
  // serial data pin
  output serial_out_t              sout_q,
  // power and status
  output logic                     analog_power_down_q,
  output logic                     digital_power_down_q,
  output logic                     busy_q,
  output logic                     rate_fault_q
);

  // synchroniser and edge-history stages, then sequencer and result registers
  logic [2:0]          cs_sync_q;
  logic [2:0]          clk_sync_q;
  seq_state_t          state_q;
  logic [2:0]          fall_cnt_q;
  logic [3:0]          bit_idx_q;
  logic [RESULT_W-1:0] held_q;
  logic [RESULT_W-1:0] sar_q;
  logic [3:0]          gap_q;

  logic cs_high;
  logic cs_fall;
  logic sclk_fall;

  // index step used in both shift directions
  function automatic logic [3:0] step_idx(input logic [3:0] idx,
                                          input logic       up);
    step_idx = up ? 4'(idx + 4'h1) : 4'(idx - 4'h1);
  endfunction

  // two flops per pin, third stage only for edge history
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cs_sync_q  <= 3'h7;
      clk_sync_q <= 3'h0;
    end else begin
      cs_sync_q  <= {cs_sync_q[1:0], pins.cs_n};
      clk_sync_q <= {clk_sync_q[1:0], pins.serial_shift_clock};
    end
  end

  // decoded pin events
  assign cs_high   = cs_sync_q[1];
  assign cs_fall   = cs_sync_q[2] & ~cs_sync_q[1];      // [RQ3]
  assign sclk_fall = clk_sync_q[2] & ~clk_sync_q[1];

  // transfer sequencer
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q    <= ST_IDLE;
      fall_cnt_q <= 3'h0;
      bit_idx_q  <= 4'h0;
    end else if (cs_high) begin
      state_q    <= ST_IDLE;                             // [RQ16] [RQ13]
      fall_cnt_q <= 3'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cs_fall) begin
            state_q    <= ST_SAMPLE;                     // [RQ3]
            fall_cnt_q <= 3'h0;
          end
        end
        ST_SAMPLE: begin
          if (sclk_fall) begin
            if (fall_cnt_q == `SAMPLE_LAST_FALL) begin
              state_q <= ST_NULL;                        // [RQ4] [RQ5]
            end else begin
              fall_cnt_q <= 3'(fall_cnt_q + 3'h1);
            end
          end
        end
        ST_NULL: begin
          if (sclk_fall) begin
            state_q   <= ST_MSBF;                        // [RQ6]
            bit_idx_q <= `RESULT_TOP_IDX;
          end
        end
        ST_MSBF: begin
          if (sclk_fall) begin
            if (bit_idx_q == `RESULT_BOTTOM_IDX) begin
              state_q   <= ST_LSBF;                      // [RQ7]
              bit_idx_q <= `RESEND_FIRST_IDX;
            end else begin
              bit_idx_q <= step_idx(bit_idx_q, 1'b0);
            end
          end
        end
        ST_LSBF: begin
          if (sclk_fall) begin
            if (bit_idx_q == `RESULT_TOP_IDX) begin
              state_q <= ST_DONE;                        // [RQ8]
            end else begin
              bit_idx_q <= step_idx(bit_idx_q, 1'b1);
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;                            // [RQ9]
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // hold the sampled code at the end of the sampling window
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      held_q <= '0;
    end else if (!cs_high && state_q == ST_SAMPLE && sclk_fall &&
                 fall_cnt_q == `SAMPLE_LAST_FALL) begin
      held_q <= analog_code;                             // [RQ10]
    end
  end

  // one comparator decision per serial clock fall
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sar_q <= '0;
    end else if (cs_high || state_q == ST_SAMPLE) begin
      sar_q <= '0;
    end else if (state_q == ST_NULL && sclk_fall) begin
      sar_q[`RESULT_TOP_IDX] <= held_q[`RESULT_TOP_IDX];  // [RQ15]
    end else if (state_q == ST_MSBF && sclk_fall &&
                 bit_idx_q != `RESULT_BOTTOM_IDX) begin
      sar_q[step_idx(bit_idx_q, 1'b0)] <=
        held_q[step_idx(bit_idx_q, 1'b0)];               // [RQ15]
    end
  end

  // serial data pin, changed only on a clock fall or cleared while select is high
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sout_q <= '0;
    end else if (cs_high) begin
      sout_q <= '0;                                      // [RQ16]
    end else if (sclk_fall) begin
      unique case (state_q)
        ST_SAMPLE: begin
          if (fall_cnt_q == `SAMPLE_LAST_FALL) begin
            sout_q <= '{dout: 1'b0, dout_oe: 1'b1};      // [RQ5]
          end
        end
        ST_NULL: begin
          sout_q <= '{dout: held_q[`RESULT_TOP_IDX],
                      dout_oe: 1'b1};                    // [RQ1] [RQ6]
        end
        ST_MSBF: begin
          if (bit_idx_q == `RESULT_BOTTOM_IDX) begin
            sout_q <= '{dout: sar_q[`RESEND_FIRST_IDX],
                        dout_oe: 1'b1};                  // [RQ7]
          end else begin
            sout_q <= '{dout: held_q[step_idx(bit_idx_q, 1'b0)],
                        dout_oe: 1'b1};                  // [RQ1]
          end
        end
        ST_LSBF: begin
          if (bit_idx_q == `RESULT_TOP_IDX) begin
            sout_q <= '0;                                // [RQ8]
          end else begin
            sout_q <= '{dout: sar_q[step_idx(bit_idx_q, 1'b1)],
                        dout_oe: 1'b1};                  // [RQ7]
          end
        end
        default: begin
          sout_q <= sout_q;
        end
      endcase
    end
  end

  // power-down and busy indications
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      analog_power_down_q  <= 1'b1;
      digital_power_down_q <= 1'b1;
      busy_q               <= 1'b0;
    end else begin
      analog_power_down_q  <= cs_high ||
                              state_q == ST_IDLE ||
                              state_q == ST_LSBF ||
                              state_q == ST_DONE; // [RQ11] [RQ12]
      digital_power_down_q <= cs_high;            // [RQ12]
      busy_q               <= !cs_high && state_q != ST_IDLE &&
                              state_q != ST_DONE;
    end
  end

  // spacing of clock falls against one bit decision time
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gap_q <= `GAP_CNT_MAX;
    end else if (sclk_fall) begin
      gap_q <= 4'h1;
    end else if (gap_q != `GAP_CNT_MAX) begin
      gap_q <= 4'(gap_q + 4'h1);
    end
  end

  // sticky fault; a fresh fault wins over the clear by select high
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rate_fault_q <= 1'b0;
    end else if (sclk_fall && busy_q &&
                 gap_q < 4'(`BIT_DECISION_CYC)) begin
      rate_fault_q <= 1'b1;                              // [RQ15]
    end else if (cs_high) begin
      rate_fault_q <= 1'b0;
    end
  end

  // checks on the sequencer and serial pin
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_SAMPLE_NO_DRIVE: assert property ( // [RQ4]
    state_q == ST_SAMPLE |-> !sout_q.dout_oe)
    else $error("output driven while sampling");

  AST_NULL_AFTER_FIFTH: assert property ( // [RQ5]
    (!cs_high && state_q == ST_SAMPLE && sclk_fall &&
     fall_cnt_q == `SAMPLE_LAST_FALL)
    |=> sout_q.dout_oe && !sout_q.dout && state_q == ST_NULL)
    else $error("null bit missing after fifth fall");

  AST_START_ON_CS_FALL: assert property ( // [RQ3]
    (state_q == ST_IDLE && cs_fall && !cs_high) |=> state_q == ST_SAMPLE)
    else $error("conversion did not start on select fall");

  AST_STEADY_BETWEEN_FALLS: assert property ( // [RQ1]
    (!sclk_fall && !cs_high) |=> $stable(sout_q))
    else $error("output changed without a clock fall");

  AST_TOP_BIT_FIRST: assert property ( // [RQ6]
    (state_q == ST_NULL && sclk_fall && !cs_high)
    |=> sout_q.dout == held_q[`RESULT_TOP_IDX] && bit_idx_q == 4'hF)
    else $error("top bit not first");

  AST_STRAIGHT_BINARY: assert property ( // [RQ10]
    (state_q == ST_MSBF && sout_q.dout_oe)
    |-> sout_q.dout == held_q[bit_idx_q])
    else $error("output bit differs from held code");

  AST_REVERSE_ORDER: assert property ( // [RQ7]
    (state_q == ST_MSBF && sclk_fall && !cs_high &&
     bit_idx_q == `RESULT_BOTTOM_IDX)
    |=> state_q == ST_LSBF && sout_q.dout == held_q[`RESEND_FIRST_IDX])
    else $error("resend did not begin bottom first");

  AST_FLOAT_WHEN_DONE: assert property ( // [RQ8]
    (state_q == ST_LSBF && sclk_fall && !cs_high &&
     bit_idx_q == `RESULT_TOP_IDX)
    |=> !sout_q.dout_oe && state_q == ST_DONE)
    else $error("output not floated after resend");

  AST_NO_RESTART: assert property ( // [RQ9]
    (state_q == ST_DONE && !cs_high) |=> state_q == ST_DONE)
    else $error("conversion restarted without select toggle");

  AST_CS_HIGH_IDLE: assert property ( // [RQ16]
    cs_high |=> !sout_q.dout_oe && state_q == ST_IDLE)
    else $error("select high but output or sequencer active");

  AST_POWER_DOWN: assert property ( // [RQ11]
    (cs_high || state_q == ST_DONE)
    |=> analog_power_down_q [*2])
    else $error("analog section not powered down");

  AST_DIGITAL_ON_LOW: assert property ( // [RQ12]
    (state_q == ST_DONE && !cs_high) |=> !digital_power_down_q)
    else $error("digital section off while select low");

  // main scenarios
  COV_FULL_TRANSFER: cover property (
    state_q == ST_LSBF ##1 state_q == ST_DONE);
  COV_SHORT_CYCLE: cover property (
    state_q == ST_MSBF && cs_high);
  COV_RATE_FAULT: cover property ($rose(rate_fault_q));

endmodule

// >>> testbench/host_master.sv
// host serial master model: select, serial clock and result capture
`timescale 1ns/1ps
module host_master
  import sar_adc_pkg::*;
(
  // host-driven pins
  output link_pins_t  pins,
  // data pin as seen from the host
  input  serial_out_t sout
);
  int          half = 100; // half serial period in ns
  int          nfall;      // falls since select went low
  logic [47:0] oe_v;       // drive enable seen after each fall
  logic [47:0] bit_v;      // wire level seen after each fall
  logic        last_q = 1'b0;
  logic        line;

  // a released wire shows the inverse of its last driven level
  always @(sout) begin
    if (sout.dout_oe) last_q = sout.dout;
  end
  assign line = sout.dout_oe ? sout.dout : ~last_q;

  // select high and clock high while no frame runs
  initial pins = '{cs_n: 1'b1, serial_shift_clock: 1'b1};

  // lower select to open a frame
  task automatic start();
    nfall = 0;
    oe_v = '0;
    bit_v = '0;
    #3;
    pins.cs_n = 1'b0;
    #(half);
  endtask

  // run n clocks, capturing the wire at each rising edge
  task automatic clocks(input int n);
    repeat (n) begin
      pins.serial_shift_clock = 1'b0;
      nfall++;
      #(half);
      pins.serial_shift_clock = 1'b1;
      oe_v[nfall] = sout.dout_oe;
      bit_v[nfall] = line;
      #(half);
    end
  endtask

  // raise select to end or cut short a frame, then rest
  task automatic stop();
    pins.cs_n = 1'b1;
    #(2 * half);
  endtask
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the serial readout sequencer
`timescale 1ns/1ps
module tb_top
  import sar_adc_pkg::*;
;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] analog_code = 16'h0000;
  link_pins_t  pins;
  serial_out_t sout_q;
  logic        apd;
  logic        dpd;
  logic        busy;
  logic        fault;
  int          failures = 0;
  int          num_checks = 0;

  // 40 MHz system clock
  always #12.5 mclk = ~mclk;

  sar_adc_serial_readout sar_adc_serial_readout_i (
    .mclk(mclk), .resetn(resetn), .pins(pins),
    .analog_code(analog_code), .sout_q(sout_q),
    .analog_power_down_q(apd), .digital_power_down_q(dpd),
    .busy_q(busy), .rate_fault_q(fault));

  host_master host_master_i (.pins(pins), .sout(sout_q));

  // compare one observed value with its expectation
  task automatic check(input string what, input logic [47:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // print the counts and the verdict, then end the run
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // present a code just after a clock edge, then open a frame
  task automatic open_frame(input logic [15:0] code);
    @(posedge mclk);
    #1;
    analog_code = code;
    host_master_i.start();
  endtask

  // whole frame with 40 clocks, select kept low past the end
  task automatic full_frame(input logic [15:0] code);
    logic [15:0] w;
    logic [15:0] r;
    open_frame(code);
    host_master_i.clocks(10);
    check("busy mid", busy, 1'h1);
    check("analog down mid", apd, 1'h0);
    host_master_i.clocks(30);
    for (int i = 0; i < 16; i++) begin
      w[15-i] = host_master_i.bit_v[6+i];
      r[i] = host_master_i.bit_v[21+i];
    end
    check("null bit", host_master_i.bit_v[5], 1'h0);
    check("top first", w, code);
    check("bottom first", r, code);
    check("enables", host_master_i.oe_v, 48'h001F_FFFF_FFE0);
    check("busy end", busy, 1'h0);
    check("analog down end", apd, 1'h1);
    check("digital down end", dpd, 1'h0);
    check("no fault", fault, 1'h0);
    host_master_i.stop();
    check("digital down idle", dpd, 1'h1);
    check("float idle", sout_q.dout_oe, 1'h0);
  endtask

  // select raised after 14 result bits
  task automatic short_cycle(input logic [15:0] code);
    logic [15:0] w;
    w = 16'h0000;
    open_frame(code);
    host_master_i.clocks(19);
    host_master_i.stop();
    for (int i = 0; i < 14; i++) w[15-i] = host_master_i.bit_v[6+i];
    check("short bits", w[15:2], code[15:2]);
    check("float abort", sout_q.dout_oe, 1'h0);
    check("busy abort", busy, 1'h0);
    check("analog down abort", apd, 1'h1);
  endtask

  // falls 150 ns apart are too close for one decision each
  task automatic fast_clock();
    host_master_i.half = 75;
    open_frame(16'h1234);
    host_master_i.clocks(8);
    check("fault set", fault, 1'h1);
    host_master_i.stop();
    check("fault cleared", fault, 1'h0);
    host_master_i.half = 100;
  endtask

  // watchdog well past the expected run length
  initial begin
    #200000;
    failures++;
    summarize();
  end

  // reset, then the scenarios
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    resetn = 1'b1;
    check("reset enable", sout_q.dout_oe, 1'h0);
    check("reset analog", apd, 1'h1);
    check("reset digital", dpd, 1'h1);
    check("reset busy", busy, 1'h0);
    check("reset fault", fault, 1'h0);
    full_frame(16'h0000);
    full_frame(16'hFFFF);
    full_frame(16'hA5C3);
    short_cycle(16'h5A3C);
    full_frame(16'h8001);
    fast_clock();
    full_frame(16'h7FFE);
    summarize();
  end
endmodule
